// ==== int_ep_ctrl.sv ====
// Purpose: Registers and handshake control of the interrupt IN endpoint.
// Assumes: Host bus pins are asynchronous; engine events share clk.
// Notes:   Writes take effect on the rising edge of the write strobe.
//          Pins reach the logic two clocks late; a write lands about
//          three clocks after the strobe rises, so hold reads five.
//          Scratch bits have no reset and stay as last written.
//          Bus reset clears control and sequence, not scratch.
//          Only the address-separate bus is served; no address latch.
//
// Notes on behaviour
// - Disabled endpoint ignores IN tokens and host ACK; rate feedback still toggles PID on packet ready
// - Stall bit answers IN with STALL
// - Type and address bits fixed, writes dropped
// - Normal mode toggles PID on host ACK
// - Rate feedback toggles PID on packet ready
// - Writing one resets sequence to DATA0
// - Upper seven toggle bits read zero
// - Scratch register is storage only
// - Scratch top bit zero, rest unreset
`include "int_ep_regs.svh"

module int_ep_ctrl
   import int_ep_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [7:0] addr,
   input wire logic [7:0] data_i,
   output logic [7:0] data_o,
   output logic data_oe,
   input wire logic usb_bus_reset,
   input wire logic in_token,
   input wire logic host_ack,
   input wire logic pkt_ready,
   output usb_answer_s answer
);

   host_bus_s bus_s;
   host_bus_s bus_prev_q;
   host_bus_s bus_prev_d;
   ctrl_s ctrl_q;
   ctrl_s ctrl_d;
   logic seq_q;
   logic seq_d;
   logic [`SCR_MSB:0] scr_q;
   logic [`SCR_MSB:0] scr_d;
   logic [7:0] rd_data_q;
   logic [7:0] rd_data_d;
   logic wr_strobe;
   logic rd_active;
   logic toggle_evt;
   logic wr_ctrl;
   logic wr_tgl;
   logic wr_scr;
   logic rd_ctrl;
   logic rd_tgl;
   logic rd_scr;

   // Address match shared by read and write decode
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction : hit

   // Control read word: mode, fixed type and address, stall, enable
   function automatic logic [7:0] ctrl_word(input ctrl_s c);
      ctrl_word = {c.toggle_mode, `CTRL_FIX_VAL, c.stall, c.cfg};
   endfunction : ctrl_word

   // Pins cross into clk before any logic looks at them
   pin_sync #(
      .WIDTH(19),
      .RST_VAL({`STROBE_IDLE, 16'h0000})
   ) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .async_i({cs_n, rd_n, wr_n, addr, data_i}),
      .sync_o(bus_s)
   );

   // Write commits when the strobe rises; address and data are taken
   // from the previous cycle, when they were still held by the master
   assign wr_strobe = bus_s.wr_n && !bus_prev_q.wr_n && !bus_prev_q.cs_n;
   assign rd_active = !bus_s.cs_n && !bus_s.rd_n;
   assign data_oe = rd_active;
   assign data_o = rd_data_q;

   // Write decode on the sample held while the strobe was still low
   assign wr_ctrl = wr_strobe && hit(bus_prev_q.addr, `CTRL_WR_ADDR);
   assign wr_tgl = wr_strobe && hit(bus_prev_q.addr, `TGL_WR_ADDR);
   assign wr_scr = wr_strobe && hit(bus_prev_q.addr, `SCR_WR_ADDR);

   // Read decode on the current synced address
   assign rd_ctrl = hit(bus_s.addr, `CTRL_RD_ADDR);
   assign rd_tgl = hit(bus_s.addr, `TGL_RD_ADDR);
   assign rd_scr = hit(bus_s.addr, `SCR_RD_ADDR);

   always_comb begin
      if (ctrl_q.toggle_mode) begin
         toggle_evt = pkt_ready;
      end else begin
         toggle_evt = host_ack && ctrl_q.cfg && !ctrl_q.stall;
      end
   end

   // Previous synced sample, kept to find the strobe edge
   always_comb begin
      bus_prev_d = bus_s;
   end

   // Strobes leave reset idle, so no false edge follows reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_prev_q <= {`STROBE_IDLE, 16'h0000};
      end else begin
         bus_prev_q <= bus_prev_d;
      end
   end

   // Next control settings; bus reset overrides a write
   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_ctrl) begin
         ctrl_d.cfg = bus_prev_q.data[`CTRL_CFG_BIT];
         ctrl_d.stall = bus_prev_q.data[`CTRL_STALL_BIT];
         ctrl_d.toggle_mode = bus_prev_q.data[`CTRL_MODE_BIT];
      end
      if (usb_bus_reset) begin
         ctrl_d = `CTRL_RST;
      end
   end

   // Control settings with defined reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= `CTRL_RST;
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   // Next sequence state
   always_comb begin
      seq_d = toggle_evt ? !seq_q : seq_q;
      if (wr_tgl && bus_prev_q.data[`TGL_SEQ_BIT]) begin
         seq_d = `SEQ_RST; // Init beats a toggle in the same cycle
      end
      if (usb_bus_reset) begin
         seq_d = `SEQ_RST;
      end
   end

   // Sequence bit, zero selects DATA0
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         seq_q <= `SEQ_RST;
      end else begin
         seq_q <= seq_d;
      end
   end

   // Next scratch value; bus reset leaves it alone
   always_comb begin
      scr_d = scr_q;
      if (wr_scr) begin
         scr_d = bus_prev_q.data[`SCR_MSB:0];
      end
   end

   // Read mux, registered so the data pins never glitch
   always_comb begin
      rd_data_d = rd_data_q;
      if (rd_active) begin
         if (rd_ctrl) begin
            rd_data_d = ctrl_word(ctrl_q);
         end else if (rd_tgl) begin
            rd_data_d = {7'h00, seq_q};
         end else if (rd_scr) begin
            rd_data_d = {1'h0, scr_q};
         end else begin
            rd_data_d = `UNMAPPED_RD;
         end
      end
   end

   // Answer toward the serial engine for an IN token
   always_comb begin
      answer = '0;
      if (in_token && ctrl_q.cfg) begin
         answer.respond = 1'b1;
         answer.stall = ctrl_q.stall;
         answer.data = !ctrl_q.stall;
         answer.pid_data1 = seq_q;
      end
   end

   // Read data register, cleared in reset so the pins start low
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_q <= `UNMAPPED_RD;
      end else begin
         rd_data_q <= rd_data_d;
      end
   end

   // Scratch bits have no reset value by design
   always_ff @(posedge clk) begin
      scr_q <= scr_d;
   end

endmodule : int_ep_ctrl

// ==== int_ep_regs.svh ====
// Purpose: Offsets, field positions and reset values of the interrupt
//          endpoint registers.
// Assumes: Included by its bare name; definitions only.
// Notes:   Read and write addresses differ for every register.
`ifndef INT_EP_REGS_SVH
`define INT_EP_REGS_SVH

// Read addresses
`define CTRL_RD_ADDR 8'hf8
`define TGL_RD_ADDR 8'hf9
`define SCR_RD_ADDR 8'hfa
// Write addresses
`define CTRL_WR_ADDR 8'h78
`define TGL_WR_ADDR 8'h79
`define SCR_WR_ADDR 8'h7a

// Control register fields
`define CTRL_CFG_BIT 0
`define CTRL_STALL_BIT 1
`define CTRL_FIX_LSB 2
`define CTRL_FIX_MSB 6
`define CTRL_MODE_BIT 7
// D6..D2: zero, transfer type 11b, endpoint address 3h
`define CTRL_FIX_VAL 5'h0f

// Toggle register field
`define TGL_SEQ_BIT 0

// Scratch register width and reset values
`define SCR_MSB 6
`define CTRL_RST 3'h0
`define SEQ_RST 1'h0
`define UNMAPPED_RD 8'h00
`define STROBE_IDLE 3'h7

`endif

// ==== int_ep_pkg.sv ====
// Purpose: Types shared by the interrupt endpoint logic.
// Assumes: Constants live in int_ep_regs.svh.
// Notes:   Structs group the control settings, the host bus and the engine answer.
package int_ep_pkg;

   // Settings software writes into the control register
   typedef struct packed {
      logic toggle_mode; // 0 normal, 1 rate feedback
      logic stall;
      logic cfg;
   } ctrl_s;

   // Host bus pins as seen after synchronisation
   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic wr_n;
      logic [7:0] addr;
      logic [7:0] data;
   } host_bus_s;

   // Handshake answer toward the serial engine
   typedef struct packed {
      logic respond;
      logic stall;
      logic data;
      logic pid_data1;
   } usb_answer_s;

endpackage : int_ep_pkg

// ==== pin_sync.sv ====
// Purpose: Two flip-flop synchroniser for asynchronous pins.
// Assumes: Reset value is a constant parameter.
// Notes:   First stage feeds only the second stage.
module pin_sync #(
   parameter int WIDTH = 19,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   // Next values of both stages
   always_comb begin
      meta_d = async_i;
      sync_d = meta_q;
   end

   // Stages registered
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_o = sync_q;

endmodule : pin_sync

// ==== int_ep_assertions.sv ====
// Purpose: Port checks of the interrupt endpoint logic.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Reads are judged after five held strobe cycles.
module int_ep_checker
   import int_ep_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic [7:0] addr,
   input wire logic [7:0] data_o,
   input wire logic usb_bus_reset,
   input wire logic in_token,
   input wire usb_answer_s answer
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Strobe held on one address, long enough for the sync delay
   sequence rd_seq(logic [7:0] a);
      (!cs_n && !rd_n && addr == a) [*5];
   endsequence
   a_idle_quiet: assert property (
      !in_token |-> answer == 4'h0) else $error("answer without token");
   a_reset_off: assert property (
      usb_bus_reset |=> !answer.respond) else $error("answer after reset");
   a_stall_only: assert property (
      answer.stall |-> !answer.data) else $error("data with stall");
   a_resp_kind: assert property (
      answer.respond |-> ^answer[2:1]) else $error("bad answer kind");
   a_pid_resp: assert property (
      answer.pid_data1 |-> answer.respond) else $error("stray pid");
   a_ctl_fixed: assert property (
      rd_seq(8'hf8) |-> data_o[6:2] == 5'h0f) else $error("fixed bits");
   a_tgl_upper: assert property (
      rd_seq(8'hf9) |-> data_o[7:1] == 7'h00) else $error("toggle upper");
   a_scr_top: assert property (
      rd_seq(8'hfa) |-> !data_o[7]) else $error("scratch top bit");
endmodule : int_ep_checker
bind int_ep_ctrl int_ep_checker i_chk (
   .clk(clk),
   .rst_n(rst_n),
   .cs_n(cs_n),
   .rd_n(rd_n),
   .addr(addr),
   .data_o(data_o),
   .usb_bus_reset(usb_bus_reset),
   .in_token(in_token),
   .answer(answer)
);

// ==== usb_host_model.sv ====
// Purpose: Host side issuing IN tokens and handshakes.
// Assumes: Moves on the falling edge; answer is combinational.
// Notes: One token per request, the handshake a cycle later.
module usb_host_model
   import int_ep_pkg::*;
(
   input wire logic clk,
   input wire logic go,
   input wire logic ack_en,
   input wire usb_answer_s answer,
   output logic in_token = 1'b0,
   output logic host_ack = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   // Token for one cycle, then handshake
   always @(negedge clk) begin
      host_ack = in_token && answer.data && ack_en;
      in_token = go && !in_token;
   end
endmodule : usb_host_model

// ==== tb.sv ====
// Purpose: Register and token tests of the interrupt endpoint.
// Assumes: Pins change on the falling edge.
// Notes: Fixed waits cover the two-stage pin sync.
module tb
   import int_ep_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rst_n = 1'b0, go = 1'b0, ack_en = 1'b0;
   logic cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1;
   logic usb_bus_reset = 1'b0, pkt_ready = 1'b0;
   logic [7:0] addr = 8'h00, data_i = 8'h00, data_o;
   logic data_oe, in_token, host_ack;
   usb_answer_s answer;
   int mismatches = 0, checks = 0;
   // Free-running clock
   always #20 clk = ~clk;
   int_ep_ctrl i_dut (
      .clk(clk),
      .rst_n(rst_n),
      .cs_n(cs_n),
      .rd_n(rd_n),
      .wr_n(wr_n),
      .addr(addr),
      .data_i(data_i),
      .data_o(data_o),
      .data_oe(data_oe),
      .usb_bus_reset(usb_bus_reset),
      .in_token(in_token),
      .host_ack(host_ack),
      .pkt_ready(pkt_ready),
      .answer(answer)
   );
   usb_host_model i_host (
      .clk(clk),
      .go(go),
      .ack_en(ack_en),
      .answer(answer),
      .in_token(in_token),
      .host_ack(host_ack)
   );
   task automatic finish_test;
      if (mismatches == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : finish_test
   task automatic chk(input string n, input logic [7:0] s, e);
      checks++;
      if (s !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, d);
      addr = a;
      data_i = d;
      cs_n = 1'b0;
      wr_n = 1'b0;
      repeat (3) @(negedge clk);
      wr_n = 1'b1;
      cs_n = 1'b1;
      repeat (6) @(negedge clk);
   endtask : wr
   task automatic rc(input logic [7:0] a, e);
      addr = a;
      cs_n = 1'b0;
      rd_n = 1'b0;
      repeat (6) @(negedge clk);
      chk("read data", data_o, e);
      chk("drive enable", {7'h00, data_oe}, 8'h01);
      cs_n = 1'b1;
      rd_n = 1'b1;
      repeat (3) @(negedge clk);
      chk("drive release", {7'h00, data_oe}, 8'h00);
   endtask : rc
   task automatic tok(input logic [3:0] e);
      go <= 1'b1;
      @(negedge clk);
      go <= 1'b0;
      @(posedge clk);
      chk("answer", {4'h0, answer}, {4'h0, e});
      repeat (3) @(negedge clk);
   endtask : tok
   // Hang guard
   initial begin
      #100000;
      mismatches++;
      finish_test();
   end
   // Main sequence
   initial begin
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      rc(8'hf8, 8'h3c);
      rc(8'hf9, 8'h00);
      wr(8'h78, 8'h40);
      rc(8'hf8, 8'h3c);
      tok(4'h0);
      wr(8'h78, 8'h01);
      ack_en = 1'b1;
      tok(4'ha);
      rc(8'hf9, 8'h01);
      wr(8'h79, 8'hff);
      rc(8'hf9, 8'h00);
      wr(8'h78, 8'h03);
      tok(4'hc);
      rc(8'hf9, 8'h00);
      wr(8'h78, 8'h81);
      pkt_ready = 1'b1;
      @(negedge clk);
      pkt_ready = 1'b0;
      rc(8'hf9, 8'h01);
      tok(4'hb);
      rc(8'hf9, 8'h01);
      wr(8'h7a, 8'hff);
      rc(8'hfa, 8'h7f);
      wr(8'h7a, 8'h2a);
      rc(8'hfa, 8'h2a);
      rc(8'hf8, 8'hbd);
      rc(8'h00, 8'h00);
      // Bus reset held over a token, so the endpoint falls silent
      usb_bus_reset = 1'b1;
      tok(4'h0);
      usb_bus_reset = 1'b0;
      rc(8'hf8, 8'h3c);
      rc(8'hf9, 8'h00);
      // Mid-run hardware reset after fresh settings
      wr(8'h78, 8'h83);
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      rc(8'hf8, 8'h3c);
      rc(8'hf9, 8'h00);
      tok(4'h0);
      finish_test();
   end
endmodule : tb
